//--- design/ref_osc_trim_registers.sv
// trim register pair of the internal reference oscillator, apb slave
// assumes factory value on flash_trim valid when flash_load pulses after reset
// assumes config_write_lock and pll_clock_select come from logic on this clock
// assumes the status flags clear on the one-cycle clear_status pulse
// apb: zero wait states, read data launched from the setup cycle
// limitation: only the low byte of pwdata is used, upper lanes ignored
`timescale 1ns/1ps
module ref_osc_trim_registers
  import osc_trim_pkg::*;
(
  input  wire logic        clk,               // 25 MHz bus clock
  input  wire logic        rst_n,             // system reset, active low
  input  wire logic        psel,              // apb select
  input  wire logic        penable,           // apb enable
  input  wire logic        pwrite,            // apb direction
  input  wire logic [11:0] paddr,             // apb byte address
  input  wire logic [31:0] pwdata,            // apb write data
  output logic      [31:0] prdata,            // apb read data
  output logic             pready,            // apb ready
  output logic             pslverr,           // apb error, unmapped
  input  wire logic        flash_load,        // factory value valid pulse
  input  wire logic [15:0] flash_trim,        // factory trim value
  input  wire logic        config_write_lock, // protection lock bit
  input  wire logic        pll_clock_select,  // pll clock selected
  output logic             clear_status,      // clears lock and osc_stable_flag
  output logic [4:0]       temp_coeff_trim,   // tc trim to oscillator
  output logic             tc_comp_enable,    // tc compensation on
  output logic [3:0]       osc_coarse_trim,   // rough frequency trim
  output logic [5:0]       osc_fine_trim      // fine frequency trim
);
  // all state in one struct: trim value, clear pulse, read data
  // rdata holds from the setup cycle until the next setup so the master
  // can take it at the access edge without racing the register update
  typedef struct packed {
    logic [15:0] trim;
    logic        clr;
    logic [31:0] rdata;
  } state_s;
  state_s st, nx;
  logic hit_hi, hit_lo, acc, wr_ok;

  // decode; apb access completes with zero wait states
  assign hit_hi = (paddr == TRIM_HIGH_ADDR);
  assign hit_lo = (paddr == TRIM_LOW_ADDR);
  assign acc    = psel && penable;
  assign wr_ok  = acc && pwrite && (hit_hi || hit_lo) && !config_write_lock;
  assign pready  = 1'b1;
  // pslverr only in the access phase; a decode miss never writes
  assign pslverr = acc && !(hit_hi || hit_lo);

  // next state
  always_comb begin
    nx = st;
    nx.clr = wr_ok && pll_clock_select;
    if (flash_load) begin
      nx.trim = flash_trim & TRIM_IMPL_MSK;
    end else if (wr_ok && hit_hi) begin
      nx.trim[15:8] = pwdata[7:0] & TRIM_IMPL_MSK[15:8];
    end else if (wr_ok && hit_lo) begin
      nx.trim[7:0] = pwdata[7:0];
    end
    // read data captured in setup; unmapped or write setups read zero
    if (psel && !penable) begin
      nx.rdata = 32'h0000_0000;
      if (!pwrite && hit_hi) nx.rdata = {24'h0, st.trim[15:8]};
      if (!pwrite && hit_lo) nx.rdata = {24'h0, st.trim[7:0]};
    end
  end

  // state register; trim holds reset value until the flash load or an accepted write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // async reset branch assigns constants only
      st <= '{trim: TRIM_RESET, clr: 1'b0, rdata: 32'h0000_0000};
    end else begin
      st <= nx;
    end
  end

  // field outputs straight from the trim flip-flops; tc_comp_enable is decoded as trim[14:11] nonzero
  assign prdata          = st.rdata;
  assign clear_status    = st.clr;
  assign temp_coeff_trim = st.trim[TC_MSB:TC_LSB];
  assign tc_comp_enable  = (st.trim[TC_MSB-1:TC_LSB] != 4'h0);
  assign osc_coarse_trim = st.trim[FREQ_MSB:COARSE_LSB];
  assign osc_fine_trim   = st.trim[COARSE_LSB-1:0];


  // a locked write must leave the trim untouched
  property p_locked_write_ignored;
    @(posedge clk) disable iff (!rst_n)
      (acc && pwrite && config_write_lock && !flash_load) |=> $stable(st.trim);
  endproperty
  a_locked_write_ignored: assert property (p_locked_write_ignored)
    else $error("locked write changed trim");

  // accepted write with pll selected pulses the clear
  property p_clear_on_pll_write;
    @(posedge clk) disable iff (!rst_n)
      (wr_ok && pll_clock_select) |=> clear_status;
  endproperty
  a_clear_on_pll_write: assert property (p_clear_on_pll_write)
    else $error("status clear missing");

  // clear only ever follows such a write
  property p_no_spurious_clear;
    @(posedge clk) disable iff (!rst_n)
      clear_status |-> $past(wr_ok) && $past(pll_clock_select);
  endproperty
  a_no_spurious_clear: assert property (p_no_spurious_clear)
    else $error("spurious status clear");

  // factory value lands one edge after the load pulse
  property p_flash_load;
    @(posedge clk) disable iff (!rst_n)
      flash_load |=> (st.trim == ($past(flash_trim) & TRIM_IMPL_MSK));
  endproperty
  a_flash_load: assert property (p_flash_load)
    else $error("flash trim not loaded");

  // unimplemented bit never set
  property p_bit10_zero;
    @(posedge clk) disable iff (!rst_n) st.trim[UNIMPL_BIT] == 1'b0;
  endproperty
  a_bit10_zero: assert property (p_bit10_zero)
    else $error("bit 10 set");

  // both nominal codes switch compensation off
  property p_tc_disable;
    @(posedge clk) disable iff (!rst_n)
      (temp_coeff_trim[3:0] == 4'h0) |-> !tc_comp_enable;
  endproperty
  a_tc_disable: assert property (p_tc_disable)
    else $error("tc compensation not off");

  // outputs mirror the packed field layout
  property p_fields;
    @(posedge clk) disable iff (!rst_n)
      {temp_coeff_trim, 1'b0, osc_coarse_trim, osc_fine_trim} == st.trim;
  endproperty
  a_fields: assert property (p_fields)
    else $error("field layout wrong");

  // low register write reaches the fine trim
  property p_low_write;
    @(posedge clk) disable iff (!rst_n)
      (wr_ok && hit_lo && !flash_load) |=> (osc_fine_trim == $past(pwdata[5:0]));
  endproperty
  a_low_write: assert property (p_low_write)
    else $error("low write lost");

  // apb never stretches a transfer
  property p_ready_always;
    @(posedge clk) disable iff (!rst_n)
      pready == 1'b1;
  endproperty
  a_ready_always: assert property (p_ready_always)
    else $error("pready low");

  // error response only in an access phase
  property p_err_in_access;
    @(posedge clk) disable iff (!rst_n)
      pslverr |-> acc;
  endproperty
  a_err_in_access: assert property (p_err_in_access)
    else $error("pslverr outside access");

  // high read returns the stored high byte
  property p_read_hi;
    @(posedge clk) disable iff (!rst_n)
      (psel && !penable && !pwrite && hit_hi) |=> (prdata == {24'h0, $past(st.trim[15:8])});
  endproperty
  a_read_hi: assert property (p_read_hi)
    else $error("high read data wrong");

  // low read returns the stored low byte
  property p_read_lo;
    @(posedge clk) disable iff (!rst_n)
      (psel && !penable && !pwrite && hit_lo) |=> (prdata == {24'h0, $past(st.trim[7:0])});
  endproperty
  a_read_lo: assert property (p_read_lo)
    else $error("low read data wrong");

  // high write lands with bit 10 masked
  property p_high_write;
    @(posedge clk) disable iff (!rst_n)
      (wr_ok && hit_hi && !flash_load) |=>
        (st.trim[15:8] == ($past(pwdata[7:0]) & TRIM_IMPL_MSK[15:8]));
  endproperty
  a_high_write: assert property (p_high_write)
    else $error("high write lost");

  // high write leaves the low byte alone
  property p_low_kept;
    @(posedge clk) disable iff (!rst_n)
      (wr_ok && hit_hi && !flash_load) |=> $stable(st.trim[7:0]);
  endproperty
  a_low_kept: assert property (p_low_kept)
    else $error("low byte disturbed");

  // any nonzero magnitude enables compensation
  property p_tc_enable;
    @(posedge clk) disable iff (!rst_n)
      (temp_coeff_trim[3:0] != 4'h0) |-> tc_comp_enable;
  endproperty
  a_tc_enable: assert property (p_tc_enable)
    else $error("tc compensation not on");

  // without load or accepted write the trim holds
  property p_idle_hold;
    @(posedge clk) disable iff (!rst_n)
      (!flash_load && !wr_ok) |=> $stable(st.trim);
  endproperty
  a_idle_hold: assert property (p_idle_hold)
    else $error("trim changed without write");

  // covers for the main scenarios
  c_flash_load: cover property (@(posedge clk) disable iff (!rst_n) flash_load);
  c_pll_write: cover property (@(posedge clk) disable iff (!rst_n) wr_ok && pll_clock_select);
  c_locked: cover property (@(posedge clk) disable iff (!rst_n) acc && pwrite && config_write_lock);
  c_read_hi: cover property (@(posedge clk) disable iff (!rst_n) acc && !pwrite && hit_hi);
endmodule // ref_osc_trim_registers

//--- design/osc_trim_pkg.sv
// constants for the reference oscillator trim register pair
// assumes an apb slave; 0x18/0x19 are word indices, byte address = 4*index
package osc_trim_pkg;
  localparam logic [7:0]  TRIM_HIGH_INDEX = 8'h18;
  localparam logic [7:0]  TRIM_LOW_INDEX  = 8'h19;
  localparam logic [11:0] TRIM_HIGH_ADDR  = {2'h0, TRIM_HIGH_INDEX, 2'h0};
  localparam logic [11:0] TRIM_LOW_ADDR   = {2'h0, TRIM_LOW_INDEX, 2'h0};
  localparam int TC_MSB     = 15;
  localparam int TC_LSB     = 11;
  localparam int UNIMPL_BIT = 10;
  localparam int FREQ_MSB   = 9;
  localparam int COARSE_LSB = 6;
  localparam logic [15:0] TRIM_RESET    = 16'h0000;
  localparam logic [15:0] TRIM_IMPL_MSK = 16'hFBFF;
endpackage

//--- verification/ref_osc_trim_registers_tb.sv
// bench for the reference oscillator trim register pair
// assumes a zero-wait apb slave and a flash load pulse after reset
`timescale 1ns/1ps
module ref_osc_trim_registers_tb;
  import osc_trim_pkg::*;
  logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, flash_load = 0;
  logic config_write_lock = 0, pll_clock_select = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [15:0] flash_trim = 16'hFFFF;
  logic pready, pslverr, clear_status, tc_comp_enable, clr, serr;
  logic [4:0] temp_coeff_trim;
  logic [3:0] osc_coarse_trim;
  logic [5:0] osc_fine_trim;
  logic [7:0] hi;
  int err_total = 0, num_checks = 0;
  typedef struct {logic lk, pl, h; logic [7:0] d; logic [15:0] ex; logic cl;} row_s;
  // lock, pll, high, data, expected trim, expected clear pulse
  row_s rows [7] = '{'{0,0,1,8'hA5,16'hA1FF,0}, '{0,1,0,8'h3C,16'hA13C,1},
    '{1,1,1,8'h00,16'hA13C,0}, '{1,0,0,8'h00,16'hA13C,0}, '{0,1,1,8'h87,16'h833C,1},
    '{0,0,0,8'h00,16'h8300,0}, '{0,0,1,8'h4A,16'h4A00,0}};
  ref_osc_trim_registers ref_osc_trim_registers_i (.clk, .rst_n, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .flash_load, .flash_trim,
    .config_write_lock, .pll_clock_select, .clear_status, .temp_coeff_trim,
    .tc_comp_enable, .osc_coarse_trim, .osc_fine_trim);
  // 25 MHz bus clock
  initial forever #20 clk = ~clk;
  task automatic conclude;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one transfer; held until ready is seen, idle edge after so calls never collide
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n = 0;
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= {24'h0, d};
    @(posedge clk) penable <= 1;
    do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 8);
    if (n >= 8) begin err_total++; conclude(); end
    rd = prdata; serr = pslverr;
    psel <= 0; penable <= 0;
    #1 clr = clear_status;
    @(posedge clk);
  endtask
  // reset, factory load, table of writes, then unmapped access and second reset
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1;
    apb(0, TRIM_HIGH_ADDR, 0); chk(rd, 0);
    flash_load <= 1;
    @(posedge clk) flash_load <= 0;
    apb(0, TRIM_HIGH_ADDR, 0); chk(rd, 32'hFB);
    apb(0, TRIM_LOW_ADDR, 0); chk(rd, 32'hFF);
    foreach (rows[i]) begin
      config_write_lock <= rows[i].lk; pll_clock_select <= rows[i].pl;
      apb(1, rows[i].h ? TRIM_HIGH_ADDR : TRIM_LOW_ADDR, rows[i].d);
      chk(clr, rows[i].cl);
      apb(0, TRIM_HIGH_ADDR, 0); hi = rd[7:0];
      apb(0, TRIM_LOW_ADDR, 0); chk({hi, rd[7:0]}, rows[i].ex);
      chk({temp_coeff_trim, tc_comp_enable, osc_coarse_trim, osc_fine_trim},
        {rows[i].ex[15:11], |rows[i].ex[14:11], rows[i].ex[9:0]});
      $display("row %0d done", i);
    end
    apb(0, 12'h068, 0); chk(rd, 0);
    chk(serr, 1);
    rst_n <= 0;
    @(posedge clk) rst_n <= 1;
    apb(0, TRIM_HIGH_ADDR, 0); chk(rd, 0);
    $display("reset and unmapped tests done");
    conclude();
  end
endmodule // ref_osc_trim_registers_tb
